// [core/ecg_regs.v]
`include "ecg_consts.vh"
module ecg_regs #(
  parameter TMR_256_CLKS = `ECG_TMR_256_US * `ECG_CLK_MHZ,
  parameter TMR_64_CLKS  = `ECG_TMR_64_US * `ECG_CLK_MHZ,
  parameter TMR_8_CLKS   = `ECG_TMR_8_US * `ECG_CLK_MHZ
) (
  // Clock and resets
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        local_rst,
  input  wire        pbr_src,
  input  wire        aux_src,
  input  wire        swr_src,
  input  wire [3:0]  strap_pins,
  input  wire        aor_strap,
  // Register access
  input  wire        reg_sel,
  input  wire        reg_wr,
  input  wire [11:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire [3:0]  reg_be,
  output reg  [31:0] reg_rdata,
  // Error status and capture sources
  input  wire        err_status_any,
  input  wire        err_event,
  input  wire        err_is_timeout,
  input  wire        err_is_pci_abort_retry,
  input  wire [31:0] cpu_addr,
  input  wire [1:0]  cpu_mid,
  input  wire        cpu_dma,
  input  wire        cpu_desc,
  input  wire        cpu_dir,
  input  wire        cpu_single,
  input  wire [2:0]  cpu_tsize,
  input  wire [4:0]  cpu_ttype,
  input  wire [31:0] pci_addr,
  input  wire        pci_dma,
  input  wire        pci_dir,
  input  wire [3:0]  pci_cmd,
  // Arbitration
  input  wire        ext_arb_mode,
  input  wire [3:0]  ext_arb_pins,
  input  wire [1:0]  int_arb_mid,
  input  wire        master_want,
  input  wire        master_beat,
  input  wire        other_req,
  output reg         master_req,
  output reg  [1:0]  cur_mid,
  // Address bus timer and address-only response
  input  wire        addr_start,
  input  wire        addr_ack,
  input  wire        ao_cycle,
  input  wire        ao_own,
  input  wire        ao_other_ack,
  output reg         ao_ack,
  output reg         bus_timeout,
  output reg  [1:0]  burst_size,
  output reg  [1:0]  timer_setting
);

  //----------------------------------------------------------------
  // Reset-time capture
  //----------------------------------------------------------------
  reg        pur_q;
  reg        pbr_q;
  reg        aux_q;
  reg        swr_q;
  reg  [3:0] strap_q;
  reg        aor_q;
  reg        pwr_seen_q;
  reg        loc_seen_q;
  wire       gcs_wr = reg_sel && reg_wr && (reg_addr == `ECG_OFF_GCS);

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pur_q      <= 1'b1;
      pbr_q      <= 1'b0;
      aux_q      <= 1'b0;
      swr_q      <= 1'b0;
      strap_q    <= 4'h0;
      aor_q      <= 1'b0;
      pwr_seen_q <= 1'b0;
      loc_seen_q <= 1'b0;
    end else begin
      if (!pwr_seen_q) begin
        pwr_seen_q <= 1'b1;
        strap_q    <= strap_pins;
        aor_q      <= aor_strap;
      end
      if (local_rst && !loc_seen_q) begin
        pbr_q <= pbr_src;
        aux_q <= aux_src;
        swr_q <= swr_src;
      end
      loc_seen_q <= local_rst;
      if (gcs_wr && reg_be[3] && (reg_wdata[31:24] == 8'h80))
        pur_q <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Writable control fields
  //----------------------------------------------------------------
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      burst_size    <= `ECG_BURST_RST;
      timer_setting <= `ECG_TMR_RST;
    end else if (local_rst) begin
      burst_size    <= `ECG_BURST_RST;
      timer_setting <= `ECG_TMR_RST;
    end else if (gcs_wr && reg_be[2]) begin
      burst_size    <= reg_wdata[`ECG_GCS_BURST_LSB+1:`ECG_GCS_BURST_LSB];
      timer_setting <= reg_wdata[`ECG_GCS_TMR_LSB+1:`ECG_GCS_TMR_LSB];
    end
  end

  //----------------------------------------------------------------
  // Error capture
  //----------------------------------------------------------------
  reg [31:0] cpu_addr_q;
  reg [31:0] cpu_attr_q;
  reg [31:0] pci_addr_q;
  reg [31:0] pci_attr_q;
  wire       self_to = err_is_timeout && (cpu_mid == `ECG_MID_SELF);
  wire       c_dma   = self_to && cpu_dma;
  wire       p_dma   = err_is_pci_abort_retry && pci_dma;

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_addr_q <= 32'h0;
      cpu_attr_q <= 32'h0;
      pci_addr_q <= 32'h0;
      pci_attr_q <= 32'h0;
    end else if (err_event && !err_status_any) begin
      cpu_addr_q <= cpu_addr;
      cpu_attr_q <= {cpu_mid, 2'h0, c_dma, c_dma && cpu_desc, c_dma && cpu_dir,
                     cpu_single, 5'h0, cpu_tsize, 3'h0, cpu_ttype, 8'h0};
      pci_addr_q <= pci_addr;
      pci_attr_q <= {p_dma, p_dma && pci_dir, 2'h0, pci_cmd, 24'h0};
    end
  end

  //----------------------------------------------------------------
  // Current master and request throttling
  //----------------------------------------------------------------
  reg [3:0] beat_cnt_q;
  reg       drop_q;
  reg [3:0] beats_lim;
  // Last beat index of each burst size; only the low four bits are ever used.
  wire [9:0] beats_64  = (`ECG_BURST_64 / `ECG_BEAT_BYTES) - 10'd1;
  wire [9:0] beats_128 = (`ECG_BURST_128 / `ECG_BEAT_BYTES) - 10'd1;
  wire [9:0] beats_256 = (`ECG_BURST_256 / `ECG_BEAT_BYTES) - 10'd1;

  always @* begin
    case (burst_size)
      2'h0:    beats_lim = beats_64[3:0];
      2'h1:    beats_lim = beats_128[3:0];
      default: beats_lim = beats_256[3:0];
    endcase
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_mid    <= `ECG_MID_CPU0;
      master_req <= 1'b0;
      beat_cnt_q <= 4'h0;
      drop_q     <= 1'b0;
    end else begin
      cur_mid <= ext_arb_mode ? ext_arb_pins[1:0] : int_arb_mid;
      if (drop_q) begin
        drop_q     <= 1'b0;
        master_req <= master_want;
      end else if (master_want && master_beat && burst_size != 2'h3 &&
                   beat_cnt_q == beats_lim) begin
        beat_cnt_q <= 4'h0;
        drop_q     <= other_req;
        master_req <= !other_req;
      end else begin
        master_req <= master_want;
        if (master_want && master_beat)
          beat_cnt_q <= beat_cnt_q + 4'h1;
        else if (!master_want)
          beat_cnt_q <= 4'h0;
      end
    end
  end

  //----------------------------------------------------------------
  // Address bus timer and address-only response
  //----------------------------------------------------------------
  reg [31:0] tmr_q;
  reg        tmr_run_q;
  reg [3:0]  ao_cnt_q;
  reg [31:0] tmr_lim;

  always @* begin
    case (timer_setting)
      2'h0:    tmr_lim = TMR_256_CLKS;
      2'h1:    tmr_lim = TMR_64_CLKS;
      default: tmr_lim = TMR_8_CLKS;
    endcase
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_q       <= 32'h0;
      tmr_run_q   <= 1'b0;
      bus_timeout <= 1'b0;
      ao_cnt_q    <= 4'h0;
      ao_ack      <= 1'b0;
    end else begin
      bus_timeout <= 1'b0;
      if (addr_start && timer_setting != 2'h3) begin
        tmr_run_q <= 1'b1;
        tmr_q     <= 32'h0;
      end else if (tmr_run_q) begin
        if (addr_ack || timer_setting == 2'h3) begin
          tmr_run_q <= 1'b0;
        end else if (tmr_q >= tmr_lim - 32'h1) begin
          tmr_run_q   <= 1'b0;
          bus_timeout <= 1'b1;
        end else begin
          tmr_q <= tmr_q + 32'h1;
        end
      end
      ao_ack <= 1'b0;
      if (!ao_cycle || ao_other_ack) begin
        ao_cnt_q <= 4'h0;
      end else if (ao_own) begin
        ao_ack <= 1'b1;
      end else if (aor_q) begin
        if (ao_cnt_q == `ECG_AO_WAIT_CLKS - 4'h1)
          ao_ack <= 1'b1;
        else
          ao_cnt_q <= ao_cnt_q + 4'h1;
      end
    end
  end

  //----------------------------------------------------------------
  // Read path
  //----------------------------------------------------------------
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_sel && !reg_wr) begin
      if (reg_addr == `ECG_OFF_ID)
        reg_rdata <= {`ECG_MAKER_CODE, `ECG_PART_CODE};
      else if (reg_addr == `ECG_OFF_REV)
        reg_rdata <= {8'h0, `ECG_REV_CODE, 16'h0};
      else if (reg_addr == `ECG_OFF_GCS)
        reg_rdata <= {pur_q, pbr_q, aux_q, swr_q, strap_q, aor_q, 1'b0,
                      burst_size, timer_setting, cur_mid, 16'h0};
      else if (reg_addr == `ECG_OFF_CPU_ADDR)
        reg_rdata <= cpu_addr_q;
      else if (reg_addr == `ECG_OFF_CPU_ATTR)
        reg_rdata <= cpu_attr_q;
      else if (reg_addr == `ECG_OFF_PCI_ADDR)
        reg_rdata <= pci_addr_q;
      else if (reg_addr == `ECG_OFF_PCI_ATTR)
        reg_rdata <= pci_attr_q;
      else
        reg_rdata <= 32'h0;
    end
  end

endmodule

// [core/ecg_consts.vh]
`ifndef ECG_CONSTS_VH
`define ECG_CONSTS_VH
// Register byte offsets within the control register group.
`define ECG_OFF_ID        12'h000
`define ECG_OFF_REV       12'h004
`define ECG_OFF_GCS       12'h010
`define ECG_OFF_CPU_ADDR  12'h070
`define ECG_OFF_CPU_ATTR  12'h074
`define ECG_OFF_PCI_ADDR  12'h078
`define ECG_OFF_PCI_ATTR  12'h07c
// Identity codes; the values are arbitrary.
`define ECG_MAKER_CODE    16'h5a5a
`define ECG_PART_CODE     16'h0c3e
`define ECG_REV_CODE      8'h11
// Master ID encoding.
`define ECG_MID_CPU0      2'h0
`define ECG_MID_CPU1      2'h1
`define ECG_MID_EXTL      2'h2
`define ECG_MID_SELF      2'h3
// Global control and status field positions.
`define ECG_GCS_PUR       31
`define ECG_GCS_PBR       30
`define ECG_GCS_AUX       29
`define ECG_GCS_SWR       28
`define ECG_GCS_STRAP_LSB 24
`define ECG_GCS_AOR       23
`define ECG_GCS_BURST_LSB 20
`define ECG_GCS_TMR_LSB   18
`define ECG_GCS_MID_LSB   16
`define ECG_GCS_RAT_LSB   13
// Reset values of writable fields.
`define ECG_BURST_RST     2'h1
`define ECG_TMR_RST       2'h0
// Burst sizes in bytes and bus beat size.
`define ECG_BURST_64      10'd64
`define ECG_BURST_128     10'd128
`define ECG_BURST_256     10'd256
`define ECG_BEAT_BYTES    10'd32
// Address bus timer lengths in microseconds, clock 100 MHz; address-only wait in clocks.
`define ECG_CLK_MHZ       100
`define ECG_TMR_256_US    256
`define ECG_TMR_64_US     64
`define ECG_TMR_8_US      8
`define ECG_AO_WAIT_CLKS  4'd8
`endif

// [test/ecg_regs_checker.sv]
`include "ecg_consts.vh"
module ecg_regs_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Register access
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  // Arbitration and bus
  input wire logic        ext_arb_mode,
  input wire logic [3:0]  ext_arb_pins,
  input wire logic [1:0]  int_arb_mid,
  input wire logic [1:0]  cur_mid,
  input wire logic        master_want,
  input wire logic        master_req,
  input wire logic        ao_cycle,
  input wire logic        ao_own,
  input wire logic        ao_ack,
  input wire logic        bus_timeout,
  input wire logic [1:0]  burst_size,
  input wire logic [1:0]  timer_setting
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ------------------------------
  // Sequences
  // ------------------------------
  sequence s_id_read;
    reg_sel && !reg_wr && reg_addr == `ECG_OFF_ID;
  endsequence
  sequence s_drop;
    $fell(master_req) && master_want && $past(master_want);
  endsequence
  property p_id_fixed;
    s_id_read |=> reg_rdata == {`ECG_MAKER_CODE, `ECG_PART_CODE};
  endproperty
  a_id_fixed: assert property (p_id_fixed) else $error("identity read wrong");
  property p_mid_ext;
    ext_arb_mode |=> cur_mid == $past(ext_arb_pins[1:0]);
  endproperty
  a_mid_ext: assert property (p_mid_ext) else $error("master id not from pins");
  property p_mid_int;
    !ext_arb_mode |=> cur_mid == $past(int_arb_mid);
  endproperty
  a_mid_int: assert property (p_mid_int) else $error("master id not from arbiter");
  property p_ao_own;
    ao_cycle && ao_own |=> ao_ack;
  endproperty
  a_ao_own: assert property (p_ao_own) else $error("own cycle not answered");
  property p_ao_idle;
    !ao_cycle |=> !ao_ack;
  endproperty
  a_ao_idle: assert property (p_ao_idle) else $error("answer without cycle");
  property p_burst_cont;
    burst_size == 2'h3 && master_want |=> master_req;
  endproperty
  a_burst_cont: assert property (p_burst_cont) else $error("continuous request dropped");
  property p_tmo_off;
    timer_setting == 2'h3 [*2] |=> !bus_timeout;
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("timeout while disabled");
  property p_drop_one;
    s_drop |=> master_req;
  endproperty
  a_drop_one: assert property (p_drop_one) else $error("request gap too long");
endmodule
bind ecg_regs ecg_regs_checker i_chk (.*);

// [test/ecg_far_model.sv]
module ecg_far_model (
  // Clock
  input  wire logic       mclk,
  // Bus master side
  input  wire logic       master_req,
  output logic            master_beat,
  // Address tenure, a delay of zero never answers
  input  wire logic       addr_start,
  input  wire logic [3:0] ack_dly,
  output logic            addr_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  initial begin
    {master_beat, addr_ack, wait_q} = '0;
  end
  // Each granted cycle carries one beat; acks come after the set delay.
  always @(posedge mclk) begin
    master_beat <= #1 master_req;
    addr_ack <= #1 wait_q == 4'h1;
    if (addr_start && ack_dly != 4'h0) begin
      wait_q <= #1 ack_dly;
    end else if (wait_q != 4'h0) begin
      wait_q <= #1 wait_q - 4'h1;
    end
  end
endmodule

// [test/testbench.sv]
`include "ecg_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, sys_rst, local_rst, pbr_src, aux_src, swr_src, aor_strap, reg_sel, reg_wr;
  logic        err_status_any, err_event, err_is_timeout, err_is_pci_abort_retry, cpu_dma;
  logic        cpu_desc, cpu_dir, cpu_single, pci_dma, pci_dir, ext_arb_mode, master_want;
  logic        master_beat, other_req, master_req, addr_start, addr_ack, ao_cycle, ao_own;
  logic        ao_other_ack, ao_ack, bus_timeout;
  logic [1:0]  cpu_mid, int_arb_mid, cur_mid, burst_size, timer_setting;
  logic [2:0]  cpu_tsize;
  logic [3:0]  strap_pins, reg_be, pci_cmd, ext_arb_pins, ack_dly;
  logic [4:0]  cpu_ttype;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cpu_addr, pci_addr, d, ea;
  int          err_total, comparisons, cyc, n, e;
  int          lims[4] = '{20, 10, 5, 99};
  ecg_regs #(.TMR_256_CLKS(20), .TMR_64_CLKS(10), .TMR_8_CLKS(5)) i_dut (.*);
  ecg_far_model i_far (.mclk(mclk), .master_req(master_req), .master_beat(master_beat),
    .addr_start(addr_start), .ack_dly(ack_dly), .addr_ack(addr_ack));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tk(int k);
    repeat (k) @(posedge mclk) #1;
  endtask
  task automatic wr(logic [11:0] a, logic [3:0] be, logic [31:0] v);
    {reg_sel, reg_wr, reg_addr, reg_be, reg_wdata} = {2'b11, a, be, v};
    tk(1);
    {reg_sel, reg_wr} = 2'b00;
    tk(1);
  endtask
  task automatic rd(logic [11:0] a);
    {reg_sel, reg_wr, reg_addr} = {2'b10, a};
    tk(1);
    d = reg_rdata;
    reg_sel = 1'b0;
    tk(1);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim, output int k);
    for (k = 0; k < lim && s !== v; k++) tk(1);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {local_rst, pbr_src, aux_src, swr_src, reg_sel, reg_wr, reg_addr, reg_be, reg_wdata,
     err_status_any, err_event, err_is_timeout, err_is_pci_abort_retry, cpu_addr, cpu_mid,
     cpu_dma, cpu_desc, cpu_dir, cpu_single, cpu_tsize, cpu_ttype, pci_addr, pci_dma, pci_dir,
     pci_cmd, ext_arb_mode, ext_arb_pins, master_want, other_req, addr_start, ao_cycle,
     ao_own, ao_other_ack, ack_dly} = '0;
    {sys_rst, aor_strap, strap_pins, int_arb_mid} = {2'b11, 4'ha, 2'h2};
    repeat (6) @(posedge mclk);
    #1 sys_rst = 1'b0;
    tk(1);
    rd(`ECG_OFF_GCS);
    check("gcs_rst", d & 32'hffbf_0000, {9'h115, 5'h4, int_arb_mid, 16'h0});
    wr(`ECG_OFF_ID, 4'hf, 32'hffff_ffff);
    rd(`ECG_OFF_ID);
    check("ident", d, {`ECG_MAKER_CODE, `ECG_PART_CODE});
    rd(`ECG_OFF_REV);
    check("rev", d[23:16], `ECG_REV_CODE);
    rd(`ECG_OFF_PCI_ADDR);
    check("pci_addr_rst", d, 32'h0);
    rd(12'h0f0);
    check("unmapped", d, 32'h0);
    {ext_arb_mode, ext_arb_pins} = 5'h11;
    tk(2);
    check("mid_ext", cur_mid, 2'h1);
    ext_arb_mode = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(`ECG_OFF_GCS, 4'h4, i * 32'h0014_0000);
      check("burst", burst_size, i);
      check("timer", timer_setting, i);
      addr_start = 1'b1;
      tk(1);
      addr_start = 1'b0;
      wait_for(bus_timeout, 1'b1, 40, n);
      check("tmo", n >= lims[i] - 2 && n <= lims[i] + 1 || i == 3 && n == 40, 1);
      {master_want, other_req} = 2'b11;
      wait_for(master_req, 1'b1, 5, n);
      wait_for(master_req, 1'b0, 20, n);
      check("drop", i == 3 ? n == 20 : n >= 2 << i && n <= (2 << i) + 2, 1);
      tk(1);
      check("req_back", master_req, 1'b1);
      master_want = 1'b0;
      tk(2);
    end
    wr(`ECG_OFF_GCS, 4'h4, 32'h0);
    {master_want, other_req} = 2'b10;
    wait_for(master_req, 1'b1, 5, n);
    wait_for(master_req, 1'b0, 20, n);
    check("no_drop", n, 20);
    master_want = 1'b0;
    tk(2);
    wr(`ECG_OFF_GCS, 4'h4, 32'h0020_0000);
    {addr_start, ack_dly} = 5'h13;
    tk(1);
    addr_start = 1'b0;
    wait_for(bus_timeout, 1'b1, 20, n);
    check("tmo_acked", n, 20);
    wr(`ECG_OFF_GCS, 4'h8, 32'hc000_0000);
    rd(`ECG_OFF_GCS);
    check("pur_kept", d[31], 1'b1);
    wr(`ECG_OFF_GCS, 4'h8, 32'h8000_0000);
    rd(`ECG_OFF_GCS);
    check("pur_clr", d[31], 1'b0);
    for (int i = 0; i < 3; i++) begin
      {pbr_src, aux_src, swr_src, local_rst} = {3'h4 >> i, 1'b1};
      tk(2);
      local_rst = 1'b0;
      rd(`ECG_OFF_GCS);
      check("src", d[31:28], 4'h4 >> i);
    end
    check("burst_lrst", burst_size, `ECG_BURST_RST);
    sys_rst = 1'b1;
    tk(2);
    sys_rst = 1'b0;
    rd(`ECG_OFF_GCS);
    check("pur_src", d[31:28], 4'h8);
    {ao_cycle, ao_own} = 2'b11;
    wait_for(ao_ack, 1'b1, 3, n);
    check("ao_own", n <= 1, 1);
    {ao_cycle, ao_own} = 2'b00;
    tk(2);
    for (int i = 0; i < 2; i++) begin
      {ao_cycle, ao_other_ack} = {1'b1, i[0]};
      wait_for(ao_ack, 1'b1, 20, n);
      check("ao_other", i ? n == 20 : n >= 7 && n <= 10, 1);
      ao_cycle = 1'b0;
      tk(2);
    end
    for (int k = 0; k < 4; k++) begin
      {cpu_dma, cpu_desc, cpu_dir, pci_dma, pci_dir, cpu_single} = {5'h1f, k[0]};
      {err_is_timeout, err_is_pci_abort_retry} = {2{k != 1}};
      {cpu_tsize, cpu_ttype, pci_cmd} = {3'(k + 1), 5'(k + 9), 4'(k + 6)};
      {cpu_mid, cpu_addr, err_status_any} = {k == 2 ? 2'h2 : 2'h3, 32'h1000 * k + 32'h44, k == 3};
      pci_addr = ~cpu_addr;
      err_event = 1'b1;
      tk(1);
      err_event = 1'b0;
      e = k == 3 ? 2 : k;
      ea = 32'h1000 * e + 32'h44;
      rd(`ECG_OFF_CPU_ADDR);
      check("cpu_addr", d, ea);
      rd(`ECG_OFF_PCI_ADDR);
      check("pci_addr", d, ~ea);
      rd(`ECG_OFF_CPU_ATTR);
      check("cpu_attr", d, {e == 2 ? 2'h2 : 2'h3, 2'h0, {3{e == 0}}, e[0], 5'h0, 3'(e + 1),
        3'h0, 5'(e + 9), 8'h0});
      rd(`ECG_OFF_PCI_ATTR);
      check("pci_attr", d, {{2{e != 1}}, 2'h0, 4'(e + 6), 24'h0});
    end
    print_verdict();
  end
endmodule
